// ===== include/scf_pkg.sv
// package: constants and types for the supply and channel fault flag bank
package scf_pkg;

    // ------------------------------------------------------------
    // flag positions
    // ------------------------------------------------------------
    localparam int unsigned BIT_DIGITAL_SUPPLY = 8;
    localparam int unsigned BIT_ANALOG_SUPPLY = 7;
    localparam int unsigned BIT_FIVE_VOLT = 6;
    localparam int unsigned BIT_CHARGE_PUMP = 5;
    localparam int unsigned BIT_OVERHEAT = 4;
    localparam int unsigned BIT_CHANNEL_D = 3;
    localparam int unsigned BIT_CHANNEL_A = 0;
    localparam int unsigned NUM_CHANNELS = 4;
    localparam int unsigned FLAG_WIDTH = 9;
    localparam int unsigned REG_WIDTH = 16;
    localparam logic [8:0] FLAGS_RESET = 9'h000;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int unsigned CLK_PERIOD_PS = 5000;
    localparam int unsigned FIXED_DEBOUNCE_US = 2000;
    // microseconds to picoseconds before dividing by the period in picoseconds
    localparam int unsigned FIXED_DEBOUNCE_CYCLES = (FIXED_DEBOUNCE_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int unsigned DEBOUNCE_CNT_WIDTH = 20;
    localparam int unsigned DEBOUNCE_SEL_WIDTH = 5;
    localparam int unsigned PROG_UNIT_CYCLES = 200;

    // ------------------------------------------------------------
    // channel functions
    // ------------------------------------------------------------
    localparam int unsigned FUNC_WIDTH = 4;
    localparam logic [3:0] FUNC_HIGH_IMPEDANCE = 4'h0;
    localparam logic [3:0] FUNC_VOLTAGE_OUT = 4'h1;
    localparam logic [3:0] FUNC_CURRENT_OUT = 4'h2;
    localparam logic [3:0] FUNC_CURRENT_IN_EXT = 4'h4;
    localparam logic [3:0] FUNC_CURRENT_IN_LOOP = 4'h5;

    // per channel configuration and raw fault indications
    typedef struct packed {
        logic [3:0] function_select;
        logic comparator_enable;
        logic comparator_half_supply;
        logic comparator_output_invert;
        logic [4:0] debounce_select;
    } scf_chan_cfg_t;

    typedef struct packed {
        logic short_circuit;
        logic open_circuit;
        logic comparator_out;
    } scf_chan_ind_t;

    typedef struct packed {
        logic digital_supply_low;
        logic analog_supply_low;
        logic five_volt_regulator_low;
        logic negative_supply_high;
        logic die_overheat;
    } scf_monitor_t;

    typedef struct packed {
        logic [19:0] count;
        logic fault;
    } scf_deb_state_t;

    typedef struct packed {
        logic [8:0] flags;
        logic [15:0] read_data;
    } scf_state_t;

endpackage : scf_pkg

// ===== verilog/scf_debounce.sv
// channel fault source selection and debounce for one channel
`timescale 1ns/1ps
module scf_debounce (
    input wire logic CLK_SYS,
    input wire logic RST,
    input scf_pkg::scf_chan_cfg_t cfg,
    input scf_pkg::scf_chan_ind_t ind,
    output logic fault_event
);
    import scf_pkg::*;

    scf_deb_state_t st;
    scf_deb_state_t next_st;
    logic raw;
    logic [19:0] limit;

    // ------------------------------------------------------------
    // source selection
    // ------------------------------------------------------------
    always_comb begin
        raw = 1'b0;
        limit = 20'(FIXED_DEBOUNCE_CYCLES); // R8 R9
        case (cfg.function_select) // R7
            FUNC_VOLTAGE_OUT: begin
                raw = ind.short_circuit; // R8
            end
            FUNC_CURRENT_OUT: begin
                raw = ind.open_circuit; // R9
            end
            FUNC_CURRENT_IN_LOOP: begin
                // short to ground shows as a low comparator, hence the invert
                raw = cfg.comparator_enable && cfg.comparator_half_supply && cfg.comparator_output_invert
                    && ind.comparator_out; // R10
                limit = 20'(cfg.debounce_select) * 20'(PROG_UNIT_CYCLES) + 20'h0_0001; // R12
            end
            FUNC_CURRENT_IN_EXT: begin
                raw = cfg.comparator_enable && cfg.comparator_half_supply && ind.comparator_out; // R11
                limit = 20'(cfg.debounce_select) * 20'(PROG_UNIT_CYCLES) + 20'h0_0001; // R12
            end
            default: begin
                raw = 1'b0;
            end
        endcase
    end

    // ------------------------------------------------------------
    // persistence counter
    // ------------------------------------------------------------
    always_comb begin
        next_st = st;
        next_st.fault = 1'b0;
        if (!raw) begin
            // any gap restarts the wait, so only continuous faults count
            next_st.count = 20'h0_0000;
        end else if (st.count < limit) begin
            next_st.count = st.count + 20'h0_0001;
            next_st.fault = (st.count + 20'h0_0001) == limit; // R8 R9 R12
        end else begin
            next_st.fault = 1'b1;
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign fault_event = st.fault;

    a_short_needs_time: assert property (@(posedge CLK_SYS) disable iff (RST)
        $rose(st.fault) && cfg.function_select == FUNC_VOLTAGE_OUT |-> $past(raw, 2)) // R8
        else $error("voltage output fault set without persisting short");
    a_gap_clears: assert property (@(posedge CLK_SYS) disable iff (RST)
        !raw |=> st.count == 20'h0_0000 && !st.fault) // R9
        else $error("debounce count not restarted after gap");
    c_fault_seen: cover property (@(posedge CLK_SYS) disable iff (RST) $rose(st.fault));

endmodule : scf_debounce

// ===== verilog/scf_flags.sv
// latched supply and channel fault flags, write one to clear
`timescale 1ns/1ps
// Operation
// [R1] digital supply below 1.93 V sets bit 8.
// [R2] analog supply below 9.26 V sets bit 7.
// [R3] five volt regulator below 4.05 V sets bit 6.
// [R4] negative supply above -1.65 V sets bit 5.
// [R5] die near 115 C sets bit 4.
// [R6] channel fault flags D..A at bits 3..0, reset zero.
// [R7] channel fault source follows that channel's selected function.
// [R8] voltage output: short circuit persisting 2 ms sets flag.
// [R9] current output: open circuit persisting 2 ms sets flag.
// [R10] loop powered input: inverted half-supply comparator flags short to ground.
// [R11] externally powered input: half-supply comparator flags over 25 mA.
// [R12] current inputs use the programmable debounce time, not 2 ms.
// [R13] writing one clears a flag; zero leaves it.
// [R14] flags stick until cleared; a coinciding event wins over clear.
module scf_flags (
    input wire logic CLK_SYS,
    input wire logic RST,
    input scf_pkg::scf_monitor_t MONITORS,
    input scf_pkg::scf_chan_cfg_t [3:0] CHAN_CFG,
    input scf_pkg::scf_chan_ind_t [3:0] CHAN_IND,
    input wire logic WRITE_STROBE,
    input wire logic [15:0] WRITE_DATA,
    output logic [15:0] FLAGS_READ
);
    import scf_pkg::*;

    scf_state_t st;
    scf_state_t next_st;
    logic [3:0] chan_event;
    logic [8:0] set_vec;
    logic [8:0] clear_vec;

    // ------------------------------------------------------------
    // channel debouncers
    // ------------------------------------------------------------
    genvar ch;
    generate
        for (ch = 0; ch < NUM_CHANNELS; ch++) begin : g_chan
            scf_debounce u_deb (
                .CLK_SYS(CLK_SYS),
                .RST(RST),
                .cfg(CHAN_CFG[ch]),
                .ind(CHAN_IND[ch]),
                .fault_event(chan_event[ch])
            );
        end
    endgenerate

    // ------------------------------------------------------------
    // flag update
    // ------------------------------------------------------------
    always_comb begin
        set_vec = 9'h000;
        set_vec[BIT_DIGITAL_SUPPLY] = MONITORS.digital_supply_low; // R1
        set_vec[BIT_ANALOG_SUPPLY] = MONITORS.analog_supply_low; // R2
        set_vec[BIT_FIVE_VOLT] = MONITORS.five_volt_regulator_low; // R3
        set_vec[BIT_CHARGE_PUMP] = MONITORS.negative_supply_high; // R4
        set_vec[BIT_OVERHEAT] = MONITORS.die_overheat; // R5
        set_vec[BIT_CHANNEL_D:BIT_CHANNEL_A] = chan_event; // R6
        clear_vec = WRITE_STROBE ? WRITE_DATA[8:0] : 9'h000; // R13
        next_st = st;
        // set after clear so a coinciding event is never lost
        next_st.flags = (st.flags & ~clear_vec) | set_vec; // R13 R14
        next_st.read_data = {7'h00, next_st.flags};
    end

    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            st.flags <= FLAGS_RESET; // R6
            st.read_data <= 16'h0000;
        end else begin
            st <= next_st;
        end
    end

    assign FLAGS_READ = st.read_data;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    a_supply_sets: assert property (@(posedge CLK_SYS) disable iff (RST)
        MONITORS.digital_supply_low |=> FLAGS_READ[BIT_DIGITAL_SUPPLY]) // R1
        else $error("digital supply flag not set");
    a_analog_sets: assert property (@(posedge CLK_SYS) disable iff (RST)
        MONITORS.analog_supply_low |=> FLAGS_READ[BIT_ANALOG_SUPPLY]) // R2
        else $error("analog supply flag not set");
    a_regulator_sets: assert property (@(posedge CLK_SYS) disable iff (RST)
        MONITORS.five_volt_regulator_low |=> FLAGS_READ[BIT_FIVE_VOLT]) // R3
        else $error("regulator flag not set");
    a_pump_sets: assert property (@(posedge CLK_SYS) disable iff (RST)
        MONITORS.negative_supply_high |=> FLAGS_READ[BIT_CHARGE_PUMP]) // R4
        else $error("charge pump flag not set");
    a_heat_sets: assert property (@(posedge CLK_SYS) disable iff (RST)
        MONITORS.die_overheat |=> FLAGS_READ[BIT_OVERHEAT]) // R5
        else $error("overheat flag not set");
    a_upper_zero: assert property (@(posedge CLK_SYS) disable iff (RST) FLAGS_READ[15:9] == 7'h00) // R6
        else $error("unused bits not zero");
    a_clear_works: assert property (@(posedge CLK_SYS) disable iff (RST)
        WRITE_STROBE && WRITE_DATA[BIT_OVERHEAT] && !MONITORS.die_overheat |=> !FLAGS_READ[BIT_OVERHEAT]) // R13
        else $error("write one did not clear");
    a_zero_keeps: assert property (@(posedge CLK_SYS) disable iff (RST)
        FLAGS_READ[BIT_DIGITAL_SUPPLY] && !(WRITE_STROBE && WRITE_DATA[BIT_DIGITAL_SUPPLY])
        |=> FLAGS_READ[BIT_DIGITAL_SUPPLY]) // R14
        else $error("flag dropped without clear");
    a_set_wins: assert property (@(posedge CLK_SYS) disable iff (RST)
        chan_event[0] && WRITE_STROBE && WRITE_DATA[BIT_CHANNEL_A] |=> FLAGS_READ[BIT_CHANNEL_A]) // R14
        else $error("event lost under clear");
    c_channel_flag: cover property (@(posedge CLK_SYS) disable iff (RST) $rose(FLAGS_READ[BIT_CHANNEL_D]));
    c_clear_flag: cover property (@(posedge CLK_SYS) disable iff (RST) $fell(FLAGS_READ[BIT_ANALOG_SUPPLY]));
    c_loop_input: cover property (@(posedge CLK_SYS) disable iff (RST)
        CHAN_CFG[1].function_select == FUNC_CURRENT_IN_LOOP && $rose(FLAGS_READ[1]));
    c_set_under_clear: cover property (@(posedge CLK_SYS) disable iff (RST)
        chan_event[0] && WRITE_STROBE && WRITE_DATA[BIT_CHANNEL_A]);

    // ------------------------------------------------------------
    // reset checks
    // ------------------------------------------------------------
    a_reset_clears: assert property (@(posedge CLK_SYS) $past(RST) |-> FLAGS_READ == 16'h0000) // R6
        else $error("flags not zero after reset");

    // ------------------------------------------------------------
    // per flag checks
    // ------------------------------------------------------------
    // every bit obeys the same latch, keep and clear behaviour
    genvar fb;
    generate
        for (fb = 0; fb < FLAG_WIDTH; fb++) begin : g_flag_chk
            a_flag_latches: assert property (@(posedge CLK_SYS) disable iff (RST) // R14
                set_vec[fb] |=> FLAGS_READ[fb])
                else $error("flag did not latch its event");
            a_flag_sticks: assert property (@(posedge CLK_SYS) disable iff (RST) // R14
                FLAGS_READ[fb] && !clear_vec[fb] |=> FLAGS_READ[fb])
                else $error("flag dropped without a clearing write");
            a_flag_clears: assert property (@(posedge CLK_SYS) disable iff (RST) // R13
                FLAGS_READ[fb] && clear_vec[fb] && !set_vec[fb] |=> !FLAGS_READ[fb])
                else $error("write of one left flag set");
            a_flag_quiet: assert property (@(posedge CLK_SYS) disable iff (RST) // R14
                !FLAGS_READ[fb] && !set_vec[fb] |=> !FLAGS_READ[fb])
                else $error("flag set without an event");
        end
    endgenerate

    // ------------------------------------------------------------
    // per channel checks
    // ------------------------------------------------------------
    genvar cc;
    generate
        for (cc = 0; cc < NUM_CHANNELS; cc++) begin : g_chan_chk
            a_chan_needs_event: assert property (@(posedge CLK_SYS) disable iff (RST) // R6
                $rose(FLAGS_READ[BIT_CHANNEL_A + cc]) |-> $past(chan_event[cc]))
                else $error("channel flag set without debounced fault");
            a_idle_function: assert property (@(posedge CLK_SYS) disable iff (RST) // R7
                CHAN_CFG[cc].function_select == FUNC_HIGH_IMPEDANCE |=> !chan_event[cc])
                else $error("fault event from a channel with no fault source");
        end
    endgenerate

endmodule : scf_flags

// ===== tb/supply_channel_fault_flags_tb.sv
// self-checking bench for the latched supply and channel fault flag bank
`timescale 1ns/1ps
module supply_channel_fault_flags_tb;
    import scf_pkg::*;

    // ------------------------------------------------------------
    // signals and design
    // ------------------------------------------------------------
    logic CLK_SYS;
    logic RST;
    scf_monitor_t mon;
    scf_chan_cfg_t [3:0] cfg;
    scf_chan_ind_t [3:0] ind;
    logic wr_stb;
    logic [15:0] wr_data;
    logic [15:0] flags;
    int n_errors;
    int n_compared;

    scf_flags scf_flags_inst (
        .CLK_SYS(CLK_SYS),
        .RST(RST),
        .MONITORS(mon),
        .CHAN_CFG(cfg),
        .CHAN_IND(ind),
        .WRITE_STROBE(wr_stb),
        .WRITE_DATA(wr_data),
        .FLAGS_READ(flags)
    );

    initial begin
        CLK_SYS = 1'b0;
        forever #2.5 CLK_SYS = ~CLK_SYS;
    end

    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_errors++;
            $display("Error at %0t: flags %h, expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic idle(input int n);
        repeat (n) @(negedge CLK_SYS);
    endtask : idle

    // strobe is taken at the rising edge between the two falling edges
    task automatic wr(input logic [15:0] d);
        @(negedge CLK_SYS);
        wr_stb = 1'b1;
        wr_data = d;
        @(negedge CLK_SYS);
        wr_stb = 1'b0;
        wr_data = 16'h0000;
    endtask : wr

    // raw indication held n cycles, then dropped; flag must latch or not
    task automatic chan(input int ch, input logic [3:0] f, input logic inv, input logic [2:0] i, input int n,
        input logic set);
        logic [15:0] e;
        e = set ? (16'h0001 << ch) : 16'h0000;
        cfg[ch] = '{f, 1'b1, 1'b1, inv, 5'h01};
        ind[ch] = i;
        idle(n);
        ind[ch] = 3'h0;
        idle(3);
        chk(flags, e);
        wr(16'h000f);
        chk(flags, 16'h0000);
        cfg[ch] = '0;
    endtask : chan

    task automatic summarize();
        $display("compared %0d, mismatches %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : summarize

    // ------------------------------------------------------------
    // tests
    // ------------------------------------------------------------
    initial begin
        logic [15:0] e;
        RST = 1'b1;
        mon = '0;
        cfg = '0;
        ind = '0;
        wr_stb = 1'b0;
        wr_data = 16'h0000;
        n_errors = 0;
        n_compared = 0;
        idle(12);
        RST = 1'b0;
        idle(1);
        chk(flags, 16'h0000);
        $display("test reset done");
        for (int b = 0; b < 5; b++) begin
            e = 16'h0010 << b;
            mon = 5'h01 << b;
            idle(1);
            mon = '0;
            idle(2);
            chk(flags, e);
            wr(16'hffff ^ e);
            chk(flags, e);
            wr(e);
            chk(flags, 16'h0000);
        end
        mon = 5'h10;
        wr(16'h0100);
        chk(flags, 16'h0100);
        mon = '0;
        idle(1);
        wr(16'h0100);
        chk(flags, 16'h0000);
        $display("test monitors done");
        // programmable debounce of one unit is 201 cycles
        for (int ch = 0; ch < 4; ch++) begin
            chan(ch, FUNC_CURRENT_IN_EXT, 1'b0, 3'h1, PROG_UNIT_CYCLES, 1'b0);
            chan(ch, FUNC_CURRENT_IN_EXT, 1'b0, 3'h1, PROG_UNIT_CYCLES + 1, 1'b1);
        end
        chan(1, FUNC_CURRENT_IN_LOOP, 1'b0, 3'h1, 250, 1'b0);
        chan(1, FUNC_CURRENT_IN_LOOP, 1'b1, 3'h1, 250, 1'b1);
        // the fixed 2 ms is too long to reach here; only early setting is caught
        chan(2, FUNC_VOLTAGE_OUT, 1'b0, 3'h4, 2000, 1'b0);
        chan(2, FUNC_VOLTAGE_OUT, 1'b0, 3'h1, 250, 1'b0);
        chan(3, FUNC_CURRENT_OUT, 1'b0, 3'h2, 2000, 1'b0);
        chan(3, FUNC_HIGH_IMPEDANCE, 1'b0, 3'h7, 250, 1'b0);
        $display("test channels done");
        // fault held through a clearing write: the set must win
        cfg[0] = '{FUNC_CURRENT_IN_EXT, 1'b1, 1'b1, 1'b0, 5'h01};
        ind[0] = 3'h1;
        idle(PROG_UNIT_CYCLES + 3);
        wr(16'h0001);
        chk(flags, 16'h0001);
        ind[0] = 3'h0;
        idle(1);
        wr(16'h0001);
        chk(flags, 16'h0000);
        cfg[0] = '0;
        $display("test set wins done");
        // reset in mid-run drops a latched flag
        mon = 5'h08;
        idle(1);
        mon = '0;
        chk(flags, 16'h0080);
        RST = 1'b1;
        idle(2);
        RST = 1'b0;
        idle(1);
        chk(flags, 16'h0000);
        $display("test second reset done");
        summarize();
    end

    initial begin
        repeat (20000) @(posedge CLK_SYS);
        n_errors++;
        $display("Error at %0t: watchdog expired", $time);
        summarize();
    end
endmodule : supply_channel_fault_flags_tb
